// ---- shared/uaf_pkg.sv ----
// Constants for the receive address filter of the two serial ports
package uaf_pkg;

   localparam int PORTS = 2;

   // Register offsets on the plain register port
   localparam logic [7:0] OFS_OWN_ADDR0 = 8'hA9;
   localparam logic [7:0] OFS_ADDR_MASK0 = 8'hB9;
   localparam logic [7:0] OFS_ADDR_MASK1 = 8'hBA;
   localparam logic [7:0] OFS_OWN_ADDR1 = 8'hBB;
   localparam logic [7:0] OFS_CTRL0 = 8'hC0;
   localparam logic [7:0] OFS_CTRL1 = 8'hC1;
   localparam logic [7:0] OFS_POWER_CTRL = 8'hC2;
   localparam logic [7:0] OFS_RX_BYTE0 = 8'hC3;
   localparam logic [7:0] OFS_RX_BYTE1 = 8'hC4;

   // Serial control register fields
   localparam int CTRL_MODE_HI_BIT = 7;
   localparam int CTRL_MODE_LO_BIT = 6;
   localparam int CTRL_MPE_BIT = 5;
   localparam int CTRL_NINTH_BIT = 2;
   localparam int CTRL_DONE_BIT = 0;

   // Power control register field
   localparam int POWER_ERR_SEL_BIT = 6;

   // Reset values
   localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
   localparam logic [7:0] ADDR_MASK_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [7:0] RX_BYTE_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Serial modes
   typedef enum logic [1:0] {
      UAF_MODE_SYNC = 2'h0,
      UAF_MODE_ASYNC8 = 2'h1,
      UAF_MODE_ASYNC9_FIXED = 2'h2,
      UAF_MODE_ASYNC9_VAR = 2'h3
   } uaf_mode_e;

endpackage

// ---- verilog/uaf_flag.sv ----
// Sticky status flag: hardware set beats software write
module uaf_flag (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Hardware event
   input wire logic set,
   // Software write
   input wire logic wr,
   input wire logic wval,
   // Flag
   output logic q
);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (wr) begin
         q <= wval;
      end
   end

endmodule

// ---- verilog/uaf_match.sv ----
// Given and broadcast address comparison for one port
module uaf_match (
   // Received address and port settings
   input wire logic [7:0] rx_addr,
   input wire logic [7:0] own_addr,
   input wire logic [7:0] addr_mask,
   // Result
   output logic hit
);

   logic [7:0] bcast;
   logic given_hit;
   logic bcast_hit;

   // Zero mask bits are don't-care
   assign given_hit = ((rx_addr ^ own_addr) & addr_mask) == 8'h00;
   // Broadcast: ones of own|mask must be received as ones
   assign bcast = own_addr | addr_mask;
   assign bcast_hit = (~rx_addr & bcast) == 8'h00;
   assign hit = given_hit | bcast_hit;

endmodule

// ---- verilog/uaf_rx_filter.sv ----
// Receive qualification: framing error, ninth-bit and address filter
//
// Function
// - Framing check only in asynchronous modes
// - Missing stop bit sets framing error
// - Control bit 7: error flag or mode
// - Framing error sticky until software clears
// - Modes 2/3 filter: ninth bit must be one
// - Enable bit ignored in mode 0
// - Mode 1 enable demands valid stop bit
// - Enable turns on hardware address compare
// - Mode 1: stop bit acts as ninth
// - Compare only where mask bit is one
// - Each port own address and mask
// - Broadcast address own OR mask accepted
// - Address and mask reset to zero
module uaf_rx_filter (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Frame events from the receive shifters
   input wire logic [1:0] frame_done,
   input wire logic [7:0] frame_byte0,
   input wire logic [7:0] frame_byte1,
   input wire logic [1:0] frame_ninth,
   input wire logic [1:0] frame_stop_ok,
   // Status towards the port cores
   output logic [1:0] receive_done_flag,
   output logic [1:0] framing_error_flag,
   // Settings towards the port cores
   output logic [1:0] multiprocessor_enable,
   output logic [1:0] serial_mode0,
   output logic [1:0] serial_mode1
);

   localparam int NP = uaf_pkg::PORTS;

   // Control byte as software sees it
   function automatic logic [7:0] ctrl_view(
      input logic sel,
      input logic [1:0] mode,
      input logic fe,
      input logic mpe,
      input logic ninth,
      input logic done
   );
      logic [7:0] v;
      v = 8'h00;
      v[uaf_pkg::CTRL_MODE_HI_BIT] = sel ? fe : mode[1];
      v[uaf_pkg::CTRL_MODE_LO_BIT] = mode[0];
      v[uaf_pkg::CTRL_MPE_BIT] = mpe;
      v[uaf_pkg::CTRL_NINTH_BIT] = ninth;
      v[uaf_pkg::CTRL_DONE_BIT] = done;
      return v;
   endfunction

   // Whether a completed frame may raise the done flag
   function automatic logic frame_pass(
      input logic [1:0] mode,
      input logic mpe,
      input logic ninth,
      input logic stop_ok,
      input logic hit
   );
      logic ok;
      ok = 1'b1;
      case (mode)
         uaf_pkg::UAF_MODE_SYNC: begin
            ok = 1'b1;
         end
         uaf_pkg::UAF_MODE_ASYNC8: begin
            // Stop bit stands in for the ninth bit here
            if (mpe) begin
               ok = stop_ok & hit;
            end
         end
         default: begin
            if (mpe) begin
               ok = ninth & hit;
            end
         end
      endcase
      return ok;
   endfunction

   // Register write decode, shared by every writable offset
   function automatic logic reg_hit(
      input logic strobe,
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      return strobe && addr == ofs;
   endfunction

   // Software settings
   logic err_sel_q;
   logic [1:0] mode_q [NP];
   logic [NP-1:0] mpe_q;
   logic [7:0] own_addr_q [NP];
   logic [7:0] addr_mask_q [NP];

   // Receive state
   logic [NP-1:0] ninth_q;
   logic [7:0] rx_byte_q [NP];

   // Per-port decode and events
   logic [7:0] frame_byte [NP];
   logic [7:0] ofs_ctrl [NP];
   logic [7:0] ofs_own [NP];
   logic [7:0] ofs_mask [NP];
   logic [7:0] ofs_rx [NP];
   logic [NP-1:0] wr_ctrl;
   logic [NP-1:0] hit;
   logic [NP-1:0] accept;
   logic [NP-1:0] fe_set;
   logic [NP-1:0] fe_wr;
   logic [7:0] rd_d;

   // Write decodes
   logic wr_power;
   logic [NP-1:0] wr_own;
   logic [NP-1:0] wr_mask;

   assign frame_byte[0] = frame_byte0;
   assign frame_byte[1] = frame_byte1;
   assign ofs_ctrl[0] = uaf_pkg::OFS_CTRL0;
   assign ofs_ctrl[1] = uaf_pkg::OFS_CTRL1;
   assign ofs_own[0] = uaf_pkg::OFS_OWN_ADDR0;
   assign ofs_own[1] = uaf_pkg::OFS_OWN_ADDR1;
   assign ofs_mask[0] = uaf_pkg::OFS_ADDR_MASK0;
   assign ofs_mask[1] = uaf_pkg::OFS_ADDR_MASK1;
   assign ofs_rx[0] = uaf_pkg::OFS_RX_BYTE0;
   assign ofs_rx[1] = uaf_pkg::OFS_RX_BYTE1;
   // Power control byte is shared by both ports
   assign wr_power = reg_hit(reg_write, reg_addr, uaf_pkg::OFS_POWER_CTRL);

   // Error-access select shared by both ports
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         err_sel_q <= 1'b0;
      end else if (wr_power) begin
         err_sel_q <= reg_wdata[uaf_pkg::POWER_ERR_SEL_BIT];
      end
   end

   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         assign wr_ctrl[p] = reg_hit(reg_write, reg_addr, ofs_ctrl[p]);
         assign wr_own[p] = reg_hit(reg_write, reg_addr, ofs_own[p]);
         assign wr_mask[p] = reg_hit(reg_write, reg_addr, ofs_mask[p]);

         // Compare uses this frame's own byte, not the latched one
         uaf_match u_match (
            .rx_addr(frame_byte[p]),
            .own_addr(own_addr_q[p]),
            .addr_mask(addr_mask_q[p]),
            .hit(hit[p])
         );

         assign accept[p] = frame_done[p] && frame_pass(mode_q[p],
            mpe_q[p], frame_ninth[p], frame_stop_ok[p], hit[p]);

         // No stop bit in mode 0, so no framing check there
         assign fe_set[p] = frame_done[p]
            && mode_q[p] != uaf_pkg::UAF_MODE_SYNC
            && !frame_stop_ok[p];
         assign fe_wr[p] = wr_ctrl[p] && err_sel_q;

         // Error-free frames never clear it; set beats write
         uaf_flag u_fe (
            .clock(clock),
            .reset(reset),
            .set(fe_set[p]),
            .wr(fe_wr[p]),
            .wval(reg_wdata[uaf_pkg::CTRL_MODE_HI_BIT]),
            .q(framing_error_flag[p])
         );

         uaf_flag u_done (
            .clock(clock),
            .reset(reset),
            .set(accept[p]),
            .wr(wr_ctrl[p]),
            .wval(reg_wdata[uaf_pkg::CTRL_DONE_BIT]),
            .q(receive_done_flag[p])
         );

         // Mode high bit kept apart from the error flag
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               mode_q[p] <= uaf_pkg::MODE_RESET;
            end else if (wr_ctrl[p]) begin
               if (!err_sel_q) begin
                  mode_q[p][1] <= reg_wdata[uaf_pkg::CTRL_MODE_HI_BIT];
               end
               mode_q[p][0] <= reg_wdata[uaf_pkg::CTRL_MODE_LO_BIT];
            end
         end

         // Software toggles this around each message
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               mpe_q[p] <= 1'b0;
            end else if (wr_ctrl[p]) begin
               mpe_q[p] <= reg_wdata[uaf_pkg::CTRL_MPE_BIT];
            end
         end

         // Received byte and ninth bit of accepted frames
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               rx_byte_q[p] <= uaf_pkg::RX_BYTE_RESET;
               ninth_q[p] <= 1'b0;
            end else if (accept[p]) begin
               rx_byte_q[p] <= frame_byte[p];
               ninth_q[p] <= frame_ninth[p];
            end
         end

         // Zero address and mask accept every address
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               own_addr_q[p] <= uaf_pkg::OWN_ADDR_RESET;
            end else if (wr_own[p]) begin
               own_addr_q[p] <= reg_wdata;
            end
         end

         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               addr_mask_q[p] <= uaf_pkg::ADDR_MASK_RESET;
            end else if (wr_mask[p]) begin
               addr_mask_q[p] <= reg_wdata;
            end
         end
      end
   endgenerate

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_d = uaf_pkg::READ_IDLE;
      if (reg_addr == uaf_pkg::OFS_POWER_CTRL) begin
         rd_d[uaf_pkg::POWER_ERR_SEL_BIT] = err_sel_q;
      end
      for (int i = 0; i < NP; i++) begin
         if (reg_addr == ofs_ctrl[i]) begin
            rd_d = ctrl_view(err_sel_q, mode_q[i],
               framing_error_flag[i], mpe_q[i], ninth_q[i],
               receive_done_flag[i]);
         end
         if (reg_addr == ofs_own[i]) begin
            rd_d = own_addr_q[i];
         end
         if (reg_addr == ofs_mask[i]) begin
            rd_d = addr_mask_q[i];
         end
         if (reg_addr == ofs_rx[i]) begin
            rd_d = rx_byte_q[i];
         end
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= uaf_pkg::READ_IDLE;
      end else if (reg_read) begin
         reg_rdata <= rd_d;
      end else begin
         reg_rdata <= uaf_pkg::READ_IDLE;
      end
   end

   // Modes mirrored to the port cores
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         serial_mode0 <= uaf_pkg::MODE_RESET;
         serial_mode1 <= uaf_pkg::MODE_RESET;
      end else begin
         serial_mode0 <= mode_q[0];
         serial_mode1 <= mode_q[1];
      end
   end

   // Port cores see the enable one cycle after the write
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         multiprocessor_enable <= 2'h0;
      end else begin
         multiprocessor_enable <= mpe_q;
      end
   end

endmodule

// ---- verif/uaf_rx_filter_checker.sv ----
// Port assertions for the receive address filter
module uaf_rx_filter_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Frame events
   input wire logic [1:0] frame_done,
   input wire logic [7:0] frame_byte0,
   input wire logic [7:0] frame_byte1,
   input wire logic [1:0] frame_ninth,
   input wire logic [1:0] frame_stop_ok,
   // Status and settings
   input wire logic [1:0] receive_done_flag,
   input wire logic [1:0] framing_error_flag,
   input wire logic [1:0] multiprocessor_enable,
   input wire logic [1:0] serial_mode0,
   input wire logic [1:0] serial_mode1
);
   logic [7:0] own0_q, msk0_q, own1_q;
   logic wr_q, quiet, hit, fd, mpe, done;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         own0_q <= 8'h00;
         msk0_q <= 8'h00;
         own1_q <= 8'h00;
         wr_q <= 1'b0;
      end else begin
         wr_q <= reg_write;
         if (reg_write && reg_addr == uaf_pkg::OFS_OWN_ADDR0) begin
            own0_q <= reg_wdata;
         end
         if (reg_write && reg_addr == uaf_pkg::OFS_ADDR_MASK0) begin
            msk0_q <= reg_wdata;
         end
         if (reg_write && reg_addr == uaf_pkg::OFS_OWN_ADDR1) begin
            own1_q <= reg_wdata;
         end
      end
   end
   // Settings outputs lag a write, so frames next to writes are skipped
   assign quiet = !wr_q && !reg_write;
   assign fd = frame_done[0] && quiet;
   assign mpe = multiprocessor_enable[0];
   assign done = receive_done_flag[0];
   assign hit = ((frame_byte0 ^ own0_q) & msk0_q) == 8'h00 ||
      (~frame_byte0 & (own0_q | msk0_q)) == 8'h00;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_addr;
      fd && mpe && serial_mode0[1] && frame_ninth[0] && !done;
   endsequence
   property p_hit; s_addr ##0 hit |=> done; endproperty
   a_hit: assert property (p_hit) else $error("hit not flagged");
   property p_miss; s_addr ##0 !hit |=> !done; endproperty
   a_miss: assert property (p_miss) else $error("miss flagged");
   property p_ninth;
      fd && mpe && serial_mode0[1] && !frame_ninth[0] && !done |=> !done;
   endproperty
   a_ninth: assert property (p_ninth) else $error("data byte flagged");
   property p_stop1;
      fd && mpe && serial_mode0 == 2'h1 && !frame_stop_ok[0] && !done
         |=> !done;
   endproperty
   a_stop1: assert property (p_stop1) else $error("bad stop flagged");
   property p_mode0; fd && serial_mode0 == 2'h0 |=> done; endproperty
   a_mode0: assert property (p_mode0) else $error("mode 0 dropped");
   property p_err;
      fd && serial_mode0 != 2'h0 && !frame_stop_ok[0]
         |=> framing_error_flag[0];
   endproperty
   a_err: assert property (p_err) else $error("error not set");
   property p_sync;
      fd && serial_mode0 == 2'h0 && !framing_error_flag[0]
         |=> !framing_error_flag[0];
   endproperty
   a_sync: assert property (p_sync) else $error("error in mode 0");
   property p_keep; framing_error_flag[0] && quiet |=> framing_error_flag[0];
   endproperty
   a_keep: assert property (p_keep) else $error("error lost");
   property p_own0;
      reg_read && reg_addr == uaf_pkg::OFS_OWN_ADDR0 |=> reg_rdata == own0_q;
   endproperty
   a_own0: assert property (p_own0) else $error("own address 0");
   property p_own1;
      reg_read && reg_addr == uaf_pkg::OFS_OWN_ADDR1 |=> reg_rdata == own1_q;
   endproperty
   a_own1: assert property (p_own1) else $error("own address 1");
endmodule
bind uaf_rx_filter uaf_rx_filter_checker u_chk (.clock, .reset, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .frame_done, .frame_byte0,
   .frame_byte1, .frame_ninth, .frame_stop_ok, .receive_done_flag,
   .framing_error_flag, .multiprocessor_enable, .serial_mode0, .serial_mode1);

// ---- verif/uaf_line_model.sv ----
// Remote sender on the serial line, as frame events
module uaf_line_model (
   // Clock
   input wire logic clock,
   // Frame events
   output logic [1:0] frame_done,
   output logic [7:0] frame_byte0,
   output logic [7:0] frame_byte1,
   output logic [1:0] frame_ninth,
   output logic [1:0] frame_stop_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_done = 2'h0;
      frame_byte0 = 8'h00;
      frame_byte1 = 8'h00;
      frame_ninth = 2'h0;
      frame_stop_ok = 2'h0;
   end
   // Ninth bit one marks an address byte, zero a data byte
   task automatic send(input int p, input logic [7:0] b, input logic adr, s);
      @(posedge clock);
      frame_done[p] <= 1'b1;
      if (p == 0) frame_byte0 <= b;
      else frame_byte1 <= b;
      frame_ninth[p] <= adr;
      frame_stop_ok[p] <= s;
      @(posedge clock);
      frame_done[p] <= 1'b0;
      // Stale lines flipped so nothing may rely on them
      frame_byte0 <= ~frame_byte0;
      frame_byte1 <= ~frame_byte1;
      frame_ninth <= ~frame_ninth;
      frame_stop_ok <= ~frame_stop_ok;
   endtask
endmodule

// ---- verif/uaf_rx_filter_tb.sv ----
// Self-checking bench for the receive address filter
module uaf_rx_filter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset, reg_write, reg_read;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, frame_byte0, frame_byte1;
   logic [1:0] frame_done, frame_ninth, frame_stop_ok, receive_done_flag;
   logic [1:0] framing_error_flag, multiprocessor_enable;
   logic [1:0] serial_mode0, serial_mode1;
   logic [7:0] oa[2], ma[2], ca[2];
   int miscompares = 0, checks_done = 0, cyc = 0;
   int own[2], msk[2], efe[2], b, mpe, st, nin, hit, edn;
   uaf_rx_filter u_dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .frame_done, .frame_byte0, .frame_byte1,
      .frame_ninth, .frame_stop_ok, .receive_done_flag, .framing_error_flag,
      .multiprocessor_enable, .serial_mode0, .serial_mode1);
   uaf_line_model u_line (.clock, .frame_done, .frame_byte0, .frame_byte1,
      .frame_ninth, .frame_stop_ok);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      rv = reg_rdata;
   endtask
   initial begin
      oa = '{uaf_pkg::OFS_OWN_ADDR0, uaf_pkg::OFS_OWN_ADDR1};
      ma = '{uaf_pkg::OFS_ADDR_MASK0, uaf_pkg::OFS_ADDR_MASK1};
      ca = '{uaf_pkg::OFS_CTRL0, uaf_pkg::OFS_CTRL1};
      efe = '{0, 0};
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      b = $urandom(70286);
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         rd(oa[p]);
         chk("own address", rv, 8'h00);
         rd(ma[p]);
         chk("mask", rv, 8'h00);
         own[p] = $urandom % 256;
         msk[p] = $urandom % 256;
      end
      for (int p = 0; p < 2; p++) begin
         wr(oa[p], 8'(own[p]));
         wr(ma[p], 8'(msk[p]));
      end
      for (int p = 0; p < 2; p++) begin
         rd(oa[p]);
         chk("own address", rv, 8'(own[p]));
         rd(ma[p]);
         chk("mask", rv, 8'(msk[p]));
      end
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 12; i++) begin
               mpe = (i % 4 != 0);
               wr(ca[p], 8'(m * 64 + mpe * 32));
               repeat (2) @(posedge clock);
               chk("mode", 8'(p ? serial_mode1 : serial_mode0), 8'(m));
               chk("enable", 8'(multiprocessor_enable[p]), 8'(mpe));
               b = $urandom % 256;
               if (i % 3 == 1) b = (own[p] & msk[p]) | (b & ~msk[p] & 255);
               if (i % 3 == 2) b = 255;
               nin = $urandom % 2;
               st = ($urandom % 4) != 0;
               hit = ((b ^ own[p]) & msk[p]) == 0 ||
                  (~b & (own[p] | msk[p])) == 0;
               edn = m == 0 || !mpe || (m == 1 ? st && hit : nin && hit);
               if (m != 0 && !st) efe[p] = 1;
               u_line.send(p, 8'(b), 1'(nin), 1'(st));
               @(negedge clock);
               chk("done", 8'(receive_done_flag[p]), 8'(edn));
               chk("error", 8'(framing_error_flag[p]), 8'(efe[p]));
            end
            wr(uaf_pkg::OFS_POWER_CTRL, 8'h40);
            rd(ca[p]);
            chk("error bit", {7'h0, rv[7]}, 8'(efe[p]));
            wr(ca[p], 8'(m % 2 * 64));
            efe[p] = 0;
            @(negedge clock);
            chk("error", {7'h0, framing_error_flag[p]}, 8'h00);
            wr(uaf_pkg::OFS_POWER_CTRL, 8'h00);
            rd(ca[p]);
            chk("mode bit", {7'h0, rv[7]}, 8'(m / 2));
         end
      end
      // One addressed message on port 0 in mode 3
      wr(ca[0], 8'hE0);
      u_line.send(0, 8'(own[0]), 1'b1, 1'b1);
      @(negedge clock);
      chk("address", 8'(receive_done_flag[0]), 8'h01);
      wr(ca[0], 8'hC0);
      u_line.send(0, 8'h5A, 1'b0, 1'b1);
      @(negedge clock);
      chk("data", 8'(receive_done_flag[0]), 8'h01);
      rd(uaf_pkg::OFS_RX_BYTE0);
      chk("received byte", rv, 8'h5A);
      wr(ca[0], 8'hE0);
      u_line.send(0, 8'hA5, 1'b0, 1'b1);
      @(negedge clock);
      chk("ignored data", 8'(receive_done_flag[0]), 8'h00);
      rd(uaf_pkg::OFS_RX_BYTE0);
      chk("received byte", rv, 8'h5A);
      results();
   end
endmodule
